// ### rfp_consts.svh
/*
 Register offsets, reset values, fields and timing counts.
 Assumes a 25 MHz system clock.
*/
`ifndef RFP_CONSTS_SVH
`define RFP_CONSTS_SVH

`define RFP_CLK_MHZ          25
// Register offsets on the decoded write/read register port
`define RFP_REG_OC_THR       8'h1A
`define RFP_REG_UV_THR       8'h1B
`define RFP_REG_OV_THR       8'h1C
`define RFP_REG_OCP_DLY      8'h1D
`define RFP_REG_PHASE_CFG    8'h1E
`define RFP_REG_VREF_CMD     8'h1F
`define RFP_REG_STATUS       8'h20
`define RFP_REG_THERM_THR    8'h29
// Reset values
`define RFP_THERM_THR_RST    8'h05
`define RFP_OC_THR_RST       8'h64
`define RFP_UV_THR_RST       8'h30
`define RFP_OV_THR_RST       8'h30
`define RFP_OCP_DLY_RST      8'h0A
`define RFP_PHASE_CFG_RST    8'h00
`define RFP_VREF_CMD_RST     8'h00
// Phase configuration register fields
`define RFP_PC_SRC_BIT       7
`define RFP_PC_ACT_MSB       2
// Analog comparison levels in ADC codes (8 bit, 2.56V full scale = FFh)
`define RFP_TOCP_LEVEL       8'hFF
`define RFP_OVP_LOW_LEVEL    8'h32
// Fixed OV/UV filter delay, in microseconds, and derived cycle count
`define RFP_VFLT_US          2
`define RFP_VFLT_CYC         (`RFP_VFLT_US * `RFP_CLK_MHZ)
// Programmable delays are counted in 1 us ticks
`define RFP_TICK_CYC         `RFP_CLK_MHZ

`endif

// ### rfp_pkg.sv
/*
 Shared types of the fault protection block.
 Assumes nothing of its surroundings.
*/
package rfp_pkg;
    typedef enum logic [1:0] {
        RFP_OUT_RUN,
        RFP_OUT_OFF,
        RFP_OUT_OV_DISCH
    } rfp_out_t;

    typedef enum logic [1:0] {
        RFP_F_NONE,
        RFP_F_OC,
        RFP_F_UV,
        RFP_F_OV
    } rfp_fault_t;
endpackage : rfp_pkg

// ### rfp_filter.sv
/*
 Persistence filter: trips once cond has held for limit ticks.
 Assumes inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rfp_filter #(
    parameter int CW = 12
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          tick,
    input  wire logic          cond,
    input  wire logic [CW-1:0] limit,
    output logic               trip
);
    import rfp_pkg::*;

    logic [CW-1:0] cnt_q;

    // Any drop in the condition restarts the count, so glitches trip only when limit is zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !cond) begin
            cnt_q <= '0;
        end else if (tick && cnt_q < limit) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trip <= 1'b0;
        end else begin
            trip <= cond && (cnt_q >= limit);
        end
    end
endmodule : rfp_filter
`default_nettype wire

// ### rfp_ocp_ratio.sv
/*
 Total overcurrent level scaling by hardware and active phase count.
 Assumes phase counts are 1..6; other codes are taken as full phase.
*/
`timescale 1ns/1ps
`default_nettype none
module rfp_ocp_ratio (
    input  wire logic [2:0] hw_phases,
    input  wire logic [2:0] act_phases,
    input  wire logic [7:0] full_level,
    output logic      [7:0] level
);
    import rfp_pkg::*;

    // Ratio in twelfths, by hardware count then active count
    function automatic logic [3:0] twelfths(input logic [2:0] hw, input logic [2:0] act);
        logic [3:0] r;
        r = 4'hC;
        if (act < hw && act != 3'h0) begin
            unique case (hw)
                3'h6: r = (act == 3'h5) ? 4'hA : (act == 3'h4) ? 4'h9 :
                          (act == 3'h3) ? 4'h8 : (act == 3'h2) ? 4'h5 : 4'h4;
                3'h5: r = (act == 3'h4) ? 4'hA : (act == 3'h3) ? 4'h8 :
                          (act == 3'h2) ? 4'h5 : 4'h4;
                3'h4: r = (act == 3'h3) ? 4'h9 : (act == 3'h2) ? 4'h8 : 4'h5;
                3'h3: r = (act == 3'h2) ? 4'h9 : 4'h5;
                3'h2: r = 4'h8;
                default: r = 4'hC;
            endcase
        end
        return r;
    endfunction : twelfths

    logic [11:0] prod;

    always_comb begin
        prod  = 12'(full_level) * 12'(twelfths(hw_phases, act_phases));
        level = 8'(prod / 12'h00C);
    end
endmodule : rfp_ocp_ratio
`default_nettype wire

// ### rfp_fault_top.sv
/*
 Fault protection and status for a two-rail multiphase regulator:
 total and per-phase overcurrent, over/undervoltage, latch-off with
 cross-rail shutdown, thermal alarm and power good; plus the register
 port. Assumes analog levels arrive as 8-bit ADC codes synchronous to
 sys_clk and that the register port is a simple decoded write/read port.
*/
// Summary of operation
// - Total overcurrent trips after programmed persistence delay
// - OC/UV trip: power good low, gates low, PWM float
// - Trip on one rail shuts the other rail
// - Trips latch; only supply or enable toggle clears
// - Total overcurrent delay comes from register
// - Total level scaled by hardware/active phase ratio
// - Active phases from CPU command or register
// - Per-phase overcurrent trips after delay, default 100uA
// - Per-phase threshold and delay are programmable
// - OV/UV monitoring armed after boot voltage reached
// - OV trips above reference plus threshold, filtered
// - OV trip: power good low, high gate low, low gate high
// - After OV, below 0.5V release low gate, float PWM
// - UV trips below reference minus threshold, filtered
// - OV/UV delays fixed, thresholds programmable
// - Thermal alarm above threshold register, default 05h
// - Thermal alarm is OR of both rails
// - Power good on ramp done, dropped on fault
// - Reference target from CPU command or register
`timescale 1ns/1ps
`default_nettype none
`include "rfp_consts.svh"
module rfp_fault_top #(
    parameter int NPH    = 6,
    parameter int DLY_CW = 12
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 supply_5v_ok,
    input  wire logic                 enable_in,
    input  wire logic [2:0]           hw_phases,
    input  wire logic [7:0]           load_current_monitor,
    input  wire logic [NPH-1:0][7:0]  phase_current_sense,
    input  wire logic [7:0]           feedback_sense,
    input  wire logic [7:0]           droop_reference,
    input  wire logic                 boot_reached,
    input  wire logic                 ramp_done,
    input  wire logic [1:0][7:0]      temp_sense_input,
    input  wire logic                 other_rail_fault,
    input  wire logic [2:0]           cpu_act_phases,
    input  wire logic [7:0]           cpu_vref_code,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    output logic                      power_good_out,
    output logic                      high_side_gate,
    output logic                      low_side_gate,
    output logic                      pwm_out,
    output logic                      pwm_oe_n,
    output logic                      thermal_alarm_n,
    output logic                      shutdown_other_rail,
    output logic      [2:0]           active_phases,
    output logic      [7:0]           vref_target
);
    import rfp_pkg::*;

    logic [7:0] therm_thr_q;
    logic [7:0] oc_thr_q;
    logic [7:0] uv_thr_q;
    logic [7:0] ov_thr_q;
    logic [7:0] ocp_dly_q;
    logic [7:0] phase_cfg_q;
    logic [7:0] vref_cmd_q;
    logic       armed_q;
    logic       vref_src_q;
    logic [4:0] tick_cnt_q;
    logic       tick;
    logic       en_q;
    logic       sup_q;
    logic       latch_clr;
    rfp_fault_t fault_q;
    rfp_out_t   out_state_q;
    logic [7:0] tocp_level;
    logic       tocp_trip;
    logic [NPH-1:0] pocp_trip;
    logic       ov_trip;
    logic       uv_trip;
    logic       ov_cond;
    logic       uv_cond;
    logic       any_trip;

    // One microsecond tick for programmable delays
    always_ff @(posedge sys_clk) begin
        if (!rst_n || tick_cnt_q == 5'(`RFP_TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = (tick_cnt_q == 5'(`RFP_TICK_CYC - 1));

    // Register writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            therm_thr_q <= `RFP_THERM_THR_RST;
            oc_thr_q    <= `RFP_OC_THR_RST;
            uv_thr_q    <= `RFP_UV_THR_RST;
            ov_thr_q    <= `RFP_OV_THR_RST;
            ocp_dly_q   <= `RFP_OCP_DLY_RST;
            phase_cfg_q <= `RFP_PHASE_CFG_RST;
            vref_cmd_q  <= `RFP_VREF_CMD_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RFP_REG_THERM_THR: therm_thr_q <= reg_wdata;
                `RFP_REG_OC_THR:    oc_thr_q    <= reg_wdata;
                `RFP_REG_UV_THR:    uv_thr_q    <= reg_wdata;
                `RFP_REG_OV_THR:    ov_thr_q    <= reg_wdata;
                `RFP_REG_OCP_DLY:   ocp_dly_q   <= reg_wdata;
                `RFP_REG_PHASE_CFG: phase_cfg_q <= reg_wdata;
                `RFP_REG_VREF_CMD:  vref_cmd_q  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Register reads; unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `RFP_REG_THERM_THR: reg_rdata <= therm_thr_q;
                `RFP_REG_OC_THR:    reg_rdata <= oc_thr_q;
                `RFP_REG_UV_THR:    reg_rdata <= uv_thr_q;
                `RFP_REG_OV_THR:    reg_rdata <= ov_thr_q;
                `RFP_REG_OCP_DLY:   reg_rdata <= ocp_dly_q;
                `RFP_REG_PHASE_CFG: reg_rdata <= phase_cfg_q;
                `RFP_REG_VREF_CMD:  reg_rdata <= vref_cmd_q;
                `RFP_REG_STATUS:    reg_rdata <= {2'b00, out_state_q, armed_q,
                                                  power_good_out, fault_q};
                default:            reg_rdata <= '0;
            endcase
        end
    end

    // Active phase count and reference source
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            active_phases <= 3'h6;
            vref_target   <= '0;
            vref_src_q    <= 1'b0;
        end else begin
            active_phases <= phase_cfg_q[`RFP_PC_SRC_BIT] ?
                             phase_cfg_q[`RFP_PC_ACT_MSB:0] : cpu_act_phases;
            vref_src_q    <= phase_cfg_q[`RFP_PC_SRC_BIT - 1];
            vref_target   <= vref_src_q ? vref_cmd_q : cpu_vref_code;
        end
    end

    rfp_ocp_ratio u_ratio (
        .hw_phases  (hw_phases),
        .act_phases (active_phases),
        .full_level (8'(`RFP_TOCP_LEVEL)),
        .level      (tocp_level)
    );

    rfp_filter #(.CW(DLY_CW)) u_tocp (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .cond    (load_current_monitor > tocp_level),
        .limit   (DLY_CW'(ocp_dly_q)),
        .trip    (tocp_trip)
    );

    // Per-phase filters, only phases below the active count, and phase 0 always, count
    generate
        for (genvar p = 0; p < NPH; p++) begin : g_pocp
            rfp_filter #(.CW(DLY_CW)) u_pocp (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .tick    (tick),
                .cond    ((3'(p) < active_phases || p == 0) &&
                          phase_current_sense[p] > oc_thr_q),
                .limit   (DLY_CW'(ocp_dly_q)),
                .trip    (pocp_trip[p])
            );
        end
    endgenerate

    // Arming after boot voltage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (boot_reached) begin
            armed_q <= 1'b1;
        end else if (latch_clr) begin
            armed_q <= 1'b0;
        end
    end

    assign ov_cond = armed_q && ({1'b0, feedback_sense} >
                                 {1'b0, droop_reference} + {1'b0, ov_thr_q});
    assign uv_cond = armed_q && ({1'b0, feedback_sense} + {1'b0, uv_thr_q} <
                                 {1'b0, droop_reference});

    rfp_filter #(.CW(DLY_CW)) u_ov (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (1'b1),
        .cond    (ov_cond),
        .limit   (DLY_CW'(`RFP_VFLT_CYC)),
        .trip    (ov_trip)
    );

    rfp_filter #(.CW(DLY_CW)) u_uv (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (1'b1),
        .cond    (uv_cond),
        .limit   (DLY_CW'(`RFP_VFLT_CYC)),
        .trip    (uv_trip)
    );

    // Latch clear on a rising edge of supply-good or enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_q  <= 1'b0;
            sup_q <= 1'b0;
        end else begin
            en_q  <= enable_in;
            sup_q <= supply_5v_ok;
        end
    end
    assign latch_clr = (enable_in && !en_q) || (supply_5v_ok && !sup_q);

    assign any_trip = tocp_trip || (|pocp_trip) || ov_trip || uv_trip || other_rail_fault;

    // Fault latch; first cause wins, later ones ignored
    always_ff @(posedge sys_clk) begin
        if (!rst_n || (latch_clr && !any_trip)) begin
            fault_q     <= RFP_F_NONE;
            out_state_q <= RFP_OUT_RUN;
        end else begin
            unique case (out_state_q)
                RFP_OUT_RUN: begin
                    if (ov_trip) begin
                        fault_q     <= RFP_F_OV;
                        out_state_q <= RFP_OUT_OV_DISCH;
                    end else if (uv_trip) begin
                        fault_q     <= RFP_F_UV;
                        out_state_q <= RFP_OUT_OFF;
                    end else if (any_trip) begin
                        fault_q     <= RFP_F_OC;
                        out_state_q <= RFP_OUT_OFF;
                    end
                end
                RFP_OUT_OV_DISCH: begin
                    if (feedback_sense < `RFP_OVP_LOW_LEVEL) begin
                        out_state_q <= RFP_OUT_OFF;
                    end
                end
                RFP_OUT_OFF: ;
            endcase
        end
    end

    // Gate and PWM outputs are registered from the current state, so they act one edge after the state changes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            high_side_gate      <= 1'b0;
            low_side_gate       <= 1'b0;
            pwm_out             <= 1'b0;
            pwm_oe_n            <= 1'b1;
            shutdown_other_rail <= 1'b0;
        end else begin
            shutdown_other_rail <= (out_state_q != RFP_OUT_RUN);
            unique case (out_state_q)
                RFP_OUT_RUN: begin
                    high_side_gate <= 1'b1;
                    low_side_gate  <= 1'b1;
                    pwm_out        <= 1'b1;
                    pwm_oe_n       <= 1'b0;
                end
                RFP_OUT_OV_DISCH: begin
                    high_side_gate <= 1'b0;
                    low_side_gate  <= 1'b1;
                    pwm_out        <= 1'b0;
                    pwm_oe_n       <= 1'b0;
                end
                RFP_OUT_OFF: begin
                    high_side_gate <= 1'b0;
                    low_side_gate  <= 1'b0;
                    pwm_out        <= 1'b0;
                    pwm_oe_n       <= 1'b1;
                end
            endcase
        end
    end

    // Power good
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            power_good_out <= 1'b0;
        end else begin
            power_good_out <= ramp_done && out_state_q == RFP_OUT_RUN && !any_trip;
        end
    end

    // Thermal alarm, active low, either rail
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            thermal_alarm_n <= 1'b1;
        end else begin
            thermal_alarm_n <= !((temp_sense_input[0] > therm_thr_q) ||
                                 (temp_sense_input[1] > therm_thr_q));
        end
    end
endmodule : rfp_fault_top
`default_nettype wire

// ### rfp_fault_monitor.sv
/*
 Port checker for rfp_fault_top, bound below.
 Assumes sys_clk and synchronous rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
module rfp_fault_monitor #(
    parameter int NPH    = 6,
    parameter int DLY_CW = 12
) (
    input wire logic            sys_clk,
    input wire logic            rst_n,
    input wire logic            supply_5v_ok,
    input wire logic            enable_in,
    input wire logic [7:0]      feedback_sense,
    input wire logic            ramp_done,
    input wire logic [1:0][7:0] temp_sense_input,
    input wire logic            other_rail_fault,
    input wire logic            power_good_out,
    input wire logic            high_side_gate,
    input wire logic            low_side_gate,
    input wire logic            pwm_oe_n,
    input wire logic            thermal_alarm_n,
    input wire logic            shutdown_other_rail
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Edges since last toggle
    logic [2:0] quiet_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || $changed(enable_in) || $changed(supply_5v_ok)) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    a_therm_cold: assert property (
        $past(temp_sense_input == 16'h0000) |-> thermal_alarm_n)
        else $error("cold alarm");
    a_shut_quiet: assert property (
        shutdown_other_rail |-> !power_good_out && !high_side_gate)
        else $error("active in shutdown");
    a_low_gate_pair: assert property (
        shutdown_other_rail |-> low_side_gate == !pwm_oe_n)
        else $error("gate/float mismatch");
    a_ov_release: assert property (
        shutdown_other_rail && low_side_gate && feedback_sense < 8'h32
        |-> ##[1:3] !low_side_gate || !shutdown_other_rail)
        else $error("low gate kept");
    a_latch_hold: assert property (
        shutdown_other_rail && quiet_q >= 3'h4 |=> shutdown_other_rail)
        else $error("latch lost");
    a_first_kept: assert property (
        shutdown_other_rail && pwm_oe_n && quiet_q >= 3'h4
        |=> pwm_oe_n && !low_side_gate)
        else $error("state changed");
    a_cross_rail: assert property (
        $rose(other_rail_fault) && quiet_q >= 3'h4 |-> ##[1:4] shutdown_other_rail)
        else $error("cross rail missed");
    a_pgood_ramp: assert property (
        power_good_out |-> $past(ramp_done))
        else $error("early power good");
    c_ov_hold: cover property (shutdown_other_rail && !pwm_oe_n);
    c_off:     cover property (shutdown_other_rail && pwm_oe_n);
    c_hot:     cover property (!thermal_alarm_n);
endmodule : rfp_fault_monitor
bind rfp_fault_top rfp_fault_monitor #(.NPH(NPH), .DLY_CW(DLY_CW)) u_rfp_fault_monitor (
    .sys_clk, .rst_n, .supply_5v_ok, .enable_in, .feedback_sense, .ramp_done,
    .temp_sense_input, .other_rail_fault, .power_good_out, .high_side_gate,
    .low_side_gate, .pwm_oe_n, .thermal_alarm_n, .shutdown_other_rail);
`default_nettype wire

// ### rfp_far_side.sv
/*
 Far side: CPU command source and gate driver.
 Assumes loads on sys_clk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module rfp_far_side (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       cmd_load,
    input  wire logic [2:0] cmd_phases,
    input  wire logic [7:0] cmd_vref,
    input  wire logic       high_side_gate,
    input  wire logic       low_side_gate,
    output logic      [2:0] cpu_act_phases,
    output logic      [7:0] cpu_vref_code,
    output logic      [1:0] fets_on
);
    // Held until next load
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cpu_act_phases <= 3'h6;
            cpu_vref_code  <= 8'h00;
        end else if (cmd_load) begin
            cpu_act_phases <= cmd_phases;
            cpu_vref_code  <= cmd_vref;
        end
    end
    // No dead time modelled
    assign fets_on = {high_side_gate, low_side_gate};
endmodule : rfp_far_side
`default_nettype wire

// ### testbench.sv
/*
 Self-checking bench for rfp_fault_top.
 Assumes design, checker and far side compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic            sys_clk, rst_n, supply_5v_ok, enable_in, boot_reached, ramp_done;
    logic            other_rail_fault, reg_wr, reg_rd, cmd_load, pwm_out, pwm_oe_n;
    logic [2:0]      hw_phases, cmd_phases, cpu_act_phases, active_phases;
    logic [7:0]      load_current_monitor, feedback_sense, droop_reference, cmd_vref;
    logic [7:0]      cpu_vref_code, reg_addr, reg_wdata, reg_rdata, vref_target, v;
    logic [5:0][7:0] phase_current_sense;
    logic [1:0][7:0] temp_sense_input;
    logic            power_good_out, high_side_gate, low_side_gate;
    logic            thermal_alarm_n, shutdown_other_rail;
    logic [1:0]      fets_on;
    int              miscompares, n_compared, h, a, r;
    int              rt [36] = '{12,0,0,0,0,0, 8,12,0,0,0,0, 5,9,12,0,0,0,
                                 5,8,9,12,0,0, 4,5,8,10,12,0, 4,5,8,9,10,12};
    rfp_fault_top #(.NPH(6), .DLY_CW(12)) u_rfp_fault_top (
        .sys_clk, .rst_n, .supply_5v_ok, .enable_in, .hw_phases, .load_current_monitor,
        .phase_current_sense, .feedback_sense, .droop_reference, .boot_reached, .ramp_done,
        .temp_sense_input, .other_rail_fault, .cpu_act_phases, .cpu_vref_code, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .power_good_out, .high_side_gate,
        .low_side_gate, .pwm_out, .pwm_oe_n, .thermal_alarm_n, .shutdown_other_rail,
        .active_phases, .vref_target);
    rfp_far_side u_rfp_far_side (
        .sys_clk, .rst_n, .cmd_load, .cmd_phases, .cmd_vref, .high_side_gate,
        .low_side_gate, .cpu_act_phases, .cpu_vref_code, .fets_on);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] oc_level(input int hw, input int act);
        return 8'(255 * rt[(hw - 1) * 6 + act - 1] / 12);
    endfunction : oc_level
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : rd
    task automatic send_cmd(input logic [2:0] ph, input logic [7:0] vr);
        @(posedge sys_clk);
        cmd_phases <= ph;
        cmd_vref <= vr;
        cmd_load <= 1'b1;
        @(posedge sys_clk);
        cmd_load <= 1'b0;
        cyc(4);
    endtask : send_cmd
    // Trip due in lo..hi edges
    task automatic trip_in(input int lo, input int hi, input logic exp);
        int n;
        n = 0;
        while (shutdown_other_rail !== 1'b1 && n < hi) begin
            @(posedge sys_clk);
            n++;
        end
        chk(8'(shutdown_other_rail), 8'(exp));
        if (exp) chk(8'(n >= lo), 8'h01);
    endtask : trip_in
    task automatic arm();
        @(posedge sys_clk);
        boot_reached <= 1'b1;
        @(posedge sys_clk);
        boot_reached <= 1'b0;
    endtask : arm
    task automatic clear_latch();
        @(posedge sys_clk);
        if ($urandom_range(1) == 1) supply_5v_ok <= 1'b0;
        else enable_in <= 1'b0;
        @(posedge sys_clk);
        supply_5v_ok <= 1'b1;
        enable_in <= 1'b1;
        cyc(6);
        chk(8'(shutdown_other_rail), 8'h00);
        chk(8'(power_good_out), 8'h01);
    endtask : clear_latch
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        cyc(20000);
        miscompares++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h0C7BFAE7));
        {rst_n, boot_reached, other_rail_fault, reg_wr, reg_rd, cmd_load} = 6'h00;
        {supply_5v_ok, enable_in, ramp_done} = 3'h7;
        {hw_phases, cmd_phases, cmd_vref, reg_addr, reg_wdata} = {3'h6, 3'h6, 24'h0};
        {load_current_monitor, feedback_sense, droop_reference} = 24'h008080;
        phase_current_sense = '0;
        temp_sense_input = '0;
        {miscompares, n_compared} = 0;
        cyc(10);
        rst_n <= 1'b1;
        chk({5'h0, active_phases}, 8'h06);
        chk(vref_target, 8'h00);
        rd(8'h29, v); chk(v, 8'h05);
        rd(8'h41, v); chk(v, 8'h00);
        for (a = 0; a < 4; a++) begin
            rd(8'(8'h1A + a), v); chk(v, a == 3 ? 8'h0A : a == 0 ? 8'h64 : 8'h30);
            r = $urandom_range(255, 0);
            wr(8'(8'h1A + a), 8'(r));
            rd(8'(8'h1A + a), v); chk(v, 8'(r));
        end
        $display("Test registers done");
        r = $urandom_range(240, 16);
        wr(8'h29, 8'(r));
        for (a = 0; a < 2; a++) begin
            temp_sense_input[a] <= 8'(r + 1);
            cyc(3); chk(8'(thermal_alarm_n), 8'h00);
            temp_sense_input[a] <= 8'(r);
            cyc(3); chk(8'(thermal_alarm_n), 8'h01);
        end
        $display("Test thermal done");
        v = 8'($urandom);
        send_cmd(3'h3, v);
        chk(vref_target, v);
        chk({5'h0, active_phases}, 8'h03);
        wr(8'h1F, ~v);
        wr(8'h1E, 8'hC2);
        cyc(3); chk(vref_target, ~v);
        chk({5'h0, active_phases}, 8'h02);
        wr(8'h1E, 8'h00);
        $display("Test command source done");
        wr(8'h1D, 8'h00);
        for (r = 0; r < 5; r++) begin
            h = r < 2 ? 6 : $urandom_range(6, 2);
            a = r == 0 ? 5 : r == 1 ? 1 : $urandom_range(h - 1, 1);
            hw_phases <= 3'(h);
            send_cmd(3'(a), 8'h40);
            chk({5'h0, active_phases}, 8'(a));
            load_current_monitor <= oc_level(h, a);
            trip_in(0, 10, 1'b0);
            load_current_monitor <= oc_level(h, a) + 8'h01;
            trip_in(0, 10, 1'b1);
            chk({power_good_out, high_side_gate, low_side_gate, pwm_oe_n}, 8'h01);
            chk({6'h0, fets_on}, 8'h00);
            rd(8'h20, v); chk(v & 8'h03, 8'h01);
            load_current_monitor <= 8'h00;
            cyc(20); chk(8'(shutdown_other_rail), 8'h01);
            clear_latch();
        end
        wr(8'h1D, 8'h03);
        load_current_monitor <= oc_level(h, a) + 8'h01;
        trip_in(50, 85, 1'b1);
        load_current_monitor <= 8'h00;
        clear_latch();
        $display("Test total overcurrent done");
        wr(8'h1D, 8'h02);
        r = $urandom_range(200, 16);
        wr(8'h1A, 8'(r));
        phase_current_sense[0] <= 8'(r);
        trip_in(0, 70, 1'b0);
        phase_current_sense[0] <= 8'(r + 1);
        trip_in(25, 60, 1'b1);
        phase_current_sense[0] <= 8'h00;
        clear_latch();
        $display("Test phase overcurrent done");
        wr(8'h1C, 8'h10);
        wr(8'h1B, 8'h10);
        feedback_sense <= 8'h91;
        trip_in(0, 80, 1'b0);
        feedback_sense <= 8'h80;
        arm();
        feedback_sense <= 8'h91;
        trip_in(45, 60, 1'b1);
        cyc(2); chk({power_good_out, high_side_gate, low_side_gate, pwm_out, pwm_oe_n}, 8'h04);
        chk({6'h0, fets_on}, 8'h01);
        rd(8'h20, v); chk(v & 8'h03, 8'h03);
        other_rail_fault <= 1'b1;
        cyc(5); chk({power_good_out, high_side_gate, low_side_gate, pwm_oe_n}, 8'h02);
        other_rail_fault <= 1'b0;
        feedback_sense <= 8'h31;
        cyc(4); chk({power_good_out, high_side_gate, low_side_gate, pwm_oe_n}, 8'h01);
        feedback_sense <= 8'h80;
        clear_latch();
        arm();
        feedback_sense <= 8'h6F;
        trip_in(45, 60, 1'b1);
        chk({power_good_out, high_side_gate, low_side_gate, pwm_oe_n}, 8'h01);
        rd(8'h20, v); chk(v & 8'h03, 8'h02);
        feedback_sense <= 8'h80;
        clear_latch();
        $display("Test voltage faults done");
        ramp_done <= 1'b0;
        cyc(3); chk(8'(power_good_out), 8'h00);
        ramp_done <= 1'b1;
        cyc(3); chk(8'(power_good_out), 8'h01);
        $display("Test power good done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
